// [acc_pkg.sv]
// constants shared by the converter control block
// assumes a classic wishbone slave with 32-bit data, one register per word
package acc_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_RESULT_LOW = 6'h04;
  localparam logic [5:0] IDX_RESULT_HIGH = 6'h05;
  localparam logic [5:0] IDX_CTRL_STATUS = 6'h06;
  localparam logic [5:0] IDX_INPUT_REF = 6'h07;

  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] INPUT_REF_RESET = 8'h00;

  // converter_control_status fields
  localparam int CS_ON = 7;
  localparam int CS_GO = 6;
  localparam int CS_FREE = 5;
  localparam int CS_FLAG = 4;
  localparam int CS_IE = 3;
  localparam int CS_DIV_LSB = 0;

  // input_reference_select fields
  localparam int IR_REF_LSB = 6;
  localparam int IR_LJ = 5;
  localparam int IR_CHAN_LSB = 0;

  // reference codes
  localparam logic [1:0] REF_PIN = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_RESERVED = 2'h2;
  localparam logic [1:0] REF_INTERNAL = 2'h3;

  // channel codes
  localparam logic [4:0] CHAN_EXT_LAST = 5'h07;
  localparam logic [4:0] CHAN_BANDGAP = 5'h1E;
  localparam logic [4:0] CHAN_GROUND = 5'h1F;

  // conversion timing in converter clock cycles
  localparam logic [4:0] NORM_CYCLES = 5'h0D;
  localparam logic [4:0] EXT_CYCLES = 5'h19;
  // sample point: whole cycles before the falling edge (1.5 and 13.5)
  localparam logic [4:0] NORM_SAMPLE = 5'h01;
  localparam logic [4:0] EXT_SAMPLE = 5'h0D;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_EXT,
    ACC_NORM
  } acc_state_e;
endpackage : acc_pkg

// [acc_top.sv]
// converter control for a 10-bit successive-approximation converter
// assumes the analog core and the processor signals share core_clk
//
// Chosen here: register access over Wishbone.
module acc_top #(
  parameter int RES_W = 10
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic cpu_sleep_halt,
  output logic done_irq_request,
  output logic cpu_wake,
  input wire logic [RES_W-1:0] sar_result,
  output logic converter_power,
  output logic converter_clk,
  output logic sample_strobe,
  output logic [1:0] active_reference,
  output logic internal_ref_on,
  output logic [4:0] active_channel,
  output logic channel_reserved
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic on;
    logic go;
    logic free;
    logic flag;
    logic ie;
    logic [2:0] div;
    logic [1:0] ref_w;
    logic lj;
    logic [4:0] chan_w;
    logic [1:0] ref_a;
    logic [4:0] chan_a;
    logic [6:0] pcnt;
    logic cclk;
    acc_pkg::acc_state_e st;
    logic [4:0] cyc;
    logic init_done;
    logic [RES_W-1:0] result;
    logic lock;
    logic sleep_d;
    logic sample;
    logic irq;
    logic wake;
    logic ref_int;
    logic chan_res;
  } acc_s;

  acc_s s;
  acc_s next_s;

  // division factor for a prescale select code
  function automatic logic [7:0] div_factor(input logic [2:0] sel);
    logic [7:0] f;
    f = 8'h02;
    if (sel != 3'h0) begin
      f = 8'h01 << sel;
    end
    return f;
  endfunction : div_factor

  // present the 10-bit result as one byte of the pair
  function automatic logic [7:0] result_byte(input logic [RES_W-1:0] r,
                                             input logic lj,
                                             input logic high);
    logic [15:0] w;
    w = 16'h0000;
    if (lj) begin
      w = {r, 6'h00};
    end else begin
      w = {6'h00, r};
    end
    return high ? w[15:8] : w[7:0];
  endfunction : result_byte

  function automatic logic reserved_chan(input logic [4:0] c);
    return (c > acc_pkg::CHAN_EXT_LAST) && (c != acc_pkg::CHAN_BANDGAP) &&
           (c != acc_pkg::CHAN_GROUND);
  endfunction : reserved_chan

  // an accepted write that addresses the given register
  function automatic logic reg_write(input logic ok,
                                     input logic [5:0] at,
                                     input logic [5:0] want);
    return ok && (at == want);
  endfunction : reg_write

  logic [7:0] factor;
  logic [7:0] half;
  logic rise_tick;
  logic fall_tick;
  logic access;
  logic wr_ok;
  logic [5:0] idx;
  logic done;

  always_comb begin
    factor = div_factor(s.div);
    half = factor >> 1;
    // at or above the top count, so a smaller divide cannot stall the clock
    rise_tick = s.on && ({1'b0, s.pcnt} >= (factor - 8'h01));
    fall_tick = s.on && ({1'b0, s.pcnt} == (half - 8'h01));
    access = wb_cyc_i && wb_stb_i && !s.ack;
    wr_ok = access && wb_we_i && wb_sel_i[0];
    idx = wb_adr_i[7:2];
    done = 1'b0;
    next_s = s;
    // registered ack: each access is answered the cycle after it is taken
    next_s.ack = access;
    next_s.sample = 1'b0;
    next_s.wake = 1'b0;
    next_s.sleep_d = cpu_sleep_halt;

    if (!s.on) begin
      next_s.pcnt = 7'h00;
      next_s.cclk = 1'b0;
    end else if (rise_tick) begin
      next_s.pcnt = 7'h00;
      next_s.cclk = 1'b1;
    end else begin
      next_s.pcnt = s.pcnt + 7'h01;
      if (fall_tick) begin
        next_s.cclk = 1'b0;
      end
    end

    case (s.st)
      acc_pkg::ACC_IDLE: begin
        if (s.on && s.go && rise_tick) begin
          next_s.cyc = 5'h00;
          next_s.ref_a = s.ref_w;
          next_s.chan_a = s.chan_w;
          next_s.st = s.init_done ? acc_pkg::ACC_NORM : acc_pkg::ACC_EXT;
        end
      end
      acc_pkg::ACC_EXT: begin
        if (fall_tick && s.cyc == acc_pkg::EXT_SAMPLE) begin
          next_s.sample = 1'b1;
        end
        if (rise_tick) begin
          if (s.cyc == acc_pkg::EXT_CYCLES - 5'h01) begin
            next_s.cyc = 5'h00;
            next_s.init_done = 1'b1;
            next_s.st = acc_pkg::ACC_NORM;
          end else begin
            next_s.cyc = s.cyc + 5'h01;
          end
        end
      end
      acc_pkg::ACC_NORM: begin
        if (fall_tick && s.cyc == acc_pkg::NORM_SAMPLE) begin
          next_s.sample = 1'b1;
        end
        if (rise_tick) begin
          if (s.cyc == acc_pkg::NORM_CYCLES - 5'h01) begin
            done = 1'b1;
            next_s.cyc = 5'h00;
            next_s.init_done = 1'b1;
            next_s.st = s.free ? acc_pkg::ACC_NORM : acc_pkg::ACC_IDLE;
          end else begin
            next_s.cyc = s.cyc + 5'h01;
          end
        end
      end
      default: begin
        next_s.st = acc_pkg::ACC_IDLE;
      end
    endcase

    if (done) begin
      // locked result is lost
      // the flag is still set below, though the locked pair keeps the older result
      // capture core output
      if (!s.lock) begin
        next_s.result = sar_result;
      end
      next_s.ref_a = s.ref_w;
      next_s.chan_a = s.chan_w;
      if (!s.free) begin
        next_s.go = 1'b0;
      end
      // completion wakes the halted cpu
      // one-cycle pulse; the processor side must latch it
      next_s.wake = cpu_sleep_halt;
    end

    // flag clears; a set in the same cycle wins
    if (irq_vector_ack) begin
      next_s.flag = 1'b0;
    end
    if (reg_write(wr_ok, idx, acc_pkg::IDX_CTRL_STATUS) &&
        wb_dat_i[acc_pkg::CS_FLAG]) begin
      next_s.flag = 1'b0;
    end
    if (done) begin
      next_s.flag = 1'b1;
    end

    // sleep-halt auto start
    // edge of the halt, so a long sleep starts one conversion only
    if (cpu_sleep_halt && !s.sleep_d && s.on && !s.go && !s.free &&
        s.ie && s.st == acc_pkg::ACC_IDLE) begin
      next_s.go = 1'b1;
    end

    if (reg_write(wr_ok, idx, acc_pkg::IDX_CTRL_STATUS)) begin
      next_s.on = wb_dat_i[acc_pkg::CS_ON];
      next_s.free = wb_dat_i[acc_pkg::CS_FREE];
      next_s.ie = wb_dat_i[acc_pkg::CS_IE];
      next_s.div = wb_dat_i[acc_pkg::CS_DIV_LSB +: 3];
      if (wb_dat_i[acc_pkg::CS_GO] && wb_dat_i[acc_pkg::CS_ON]) begin
        next_s.go = 1'b1;
      end
    end
    if (reg_write(wr_ok, idx, acc_pkg::IDX_INPUT_REF)) begin
      next_s.ref_w = wb_dat_i[acc_pkg::IR_REF_LSB +: 2];
      next_s.lj = wb_dat_i[acc_pkg::IR_LJ];
      next_s.chan_w = wb_dat_i[acc_pkg::IR_CHAN_LSB +: 5];
    end

    // off aborts and rearms the extended conversion
    // go is cleared too, so a later enable alone never starts a conversion
    if (!next_s.on) begin
      next_s.go = 1'b0;
      next_s.st = acc_pkg::ACC_IDLE;
      next_s.cyc = 5'h00;
      next_s.init_done = 1'b0;
    end

    next_s.rdata = 32'h00000000;
    if (access && !wb_we_i) begin
      case (idx)
        acc_pkg::IDX_RESULT_LOW: begin
          next_s.rdata[7:0] = result_byte(s.result, s.lj, 1'b0);
          // low read locks
          // any low read locks, so a stray one freezes the pair until high
          next_s.lock = 1'b1;
        end
        acc_pkg::IDX_RESULT_HIGH: begin
          next_s.rdata[7:0] = result_byte(s.result, s.lj, 1'b1);
          next_s.lock = 1'b0;
        end
        acc_pkg::IDX_CTRL_STATUS: begin
          next_s.rdata[7:0] = {s.on, s.go, s.free, s.flag, s.ie, s.div};
        end
        acc_pkg::IDX_INPUT_REF: begin
          next_s.rdata[7:0] = {s.ref_w, s.lj, s.chan_w};
        end
        default: begin
          next_s.rdata = 32'h00000000;
        end
      endcase
    end

    next_s.irq = s.flag && s.ie && global_irq_enable;

    // internal reference follows the applied selection
    next_s.ref_int = next_s.ref_a == acc_pkg::REF_INTERNAL;
    // reserved mark for the applied channel
    next_s.chan_res = reserved_chan(next_s.chan_a);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // on, div, ref_w and chan_w take the package reset values; the rest clears
      s <= '0;
      s.on <= acc_pkg::CTRL_STATUS_RESET[acc_pkg::CS_ON];
      s.div <= acc_pkg::CTRL_STATUS_RESET[2:0];
      s.ref_w <= acc_pkg::INPUT_REF_RESET[7:6];
      s.chan_w <= acc_pkg::INPUT_REF_RESET[4:0];
      s.st <= acc_pkg::ACC_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign done_irq_request = s.irq;
  assign cpu_wake = s.wake;
  assign converter_power = s.on;
  assign converter_clk = s.cclk;
  assign sample_strobe = s.sample;
  assign active_reference = s.ref_a;
  assign internal_ref_on = s.ref_int;
  assign active_channel = s.chan_a;
  assign channel_reserved = s.chan_res;

endmodule : acc_top

// [acc_props.sv]
// checker for the converter control block ports
// assumes binding onto acc_top; one clock, synchronous reset
module acc_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic global_irq_enable,
  input wire logic done_irq_request,
  input wire logic converter_power,
  input wire logic converter_clk,
  input wire logic sample_strobe,
  input wire logic [1:0] active_reference,
  input wire logic internal_ref_on,
  input wire logic [4:0] active_channel,
  input wire logic channel_reserved
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_off; !converter_power [*3]; endsequence
  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_top; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  property p_off; s_off |-> !converter_clk; endproperty
  // half period is at most 64 core cycles, the divide-by-128 case
  property p_half;
    $changed(converter_clk) |->
      ##[1:64] ($changed(converter_clk) || !converter_power);
  endproperty
  property p_smp;
    sample_strobe |-> $past(converter_power) ##1 !sample_strobe;
  endproperty
  property p_irq; !global_irq_enable |=> !done_irq_request; endproperty
  property p_ref;
    internal_ref_on == (active_reference == acc_pkg::REF_INTERNAL);
  endproperty
  property p_chan;
    channel_reserved == (active_channel > acc_pkg::CHAN_EXT_LAST &&
      active_channel < acc_pkg::CHAN_BANDGAP);
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  a_top: assert property (p_top) else $error("upper read bits set");
  a_off: assert property (p_off) else $error("clock while off");
  a_half: assert property (p_half) else $error("clock too slow");
  a_smp: assert property (p_smp) else $error("bad sample pulse");
  a_irq: assert property (p_irq) else $error("irq while masked");
  a_ref: assert property (p_ref) else $error("internal ref state");
  a_chan: assert property (p_chan) else $error("reserved channel");
endmodule : acc_props
bind acc_top acc_props acc_props_inst (.core_clk, .sys_rst, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_dat_o, .global_irq_enable, .done_irq_request,
  .converter_power, .converter_clk, .sample_strobe, .active_reference,
  .internal_ref_on, .active_channel, .channel_reserved);

// [acc_core_model.sv]
// behavioural analog core: sample-and-hold with a finished code
// assumes the bench supplies the code that the next sample yields
module acc_core_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic converter_power,
  input wire logic sample_strobe,
  input wire logic [9:0] sample_value,
  output logic [9:0] sar_result
);
  logic [9:0] held;
  always_ff @(posedge core_clk) begin
    if (sys_rst) held <= 10'h000;
    else if (sample_strobe) held <= sample_value;
  end
  // an unpowered core has no valid code, so never show the last one
  assign sar_result = converter_power ? held : ~held;
endmodule : acc_core_model

// [test_adc_conversion_control.sv]
// self-checking bench for the converter control block
// assumes the design, the core model and the bound checker
module test_adc_conversion_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] CS = acc_pkg::IDX_CTRL_STATUS;
  localparam logic [5:0] IR = acc_pkg::IDX_INPUT_REF;
  logic core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, clk_q;
  logic global_irq_enable, irq_vector_ack, cpu_sleep_halt, cpu_wake;
  logic done_irq_request, converter_power, converter_clk, sample_strobe;
  logic internal_ref_on, channel_reserved;
  logic [1:0] active_reference;
  logic [3:0] wb_sel_i;
  logic [4:0] active_channel;
  logic [7:0] wb_adr_i, ir, rdat, lo;
  logic [9:0] sar_result, nxt;
  logic [31:0] wb_dat_i, wb_dat_o;
  int n_mismatch = 0, checked = 0, n_strobe = 0, gap = 0, rises = 0;
  int per = 0, ccnt = 0, base, n;
  acc_top acc_top_inst (.core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .global_irq_enable, .irq_vector_ack, .cpu_sleep_halt,
    .done_irq_request, .cpu_wake, .sar_result, .converter_power,
    .converter_clk, .sample_strobe, .active_reference, .internal_ref_on,
    .active_channel, .channel_reserved);
  acc_core_model acc_core_model_inst (.core_clk, .sys_rst,
    .converter_power, .sample_strobe, .sample_value(nxt), .sar_result);
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  // divided clock period and rises between sample points
  always @(posedge core_clk) begin
    clk_q <= converter_clk;
    ccnt <= ccnt + 1;
    if (converter_clk && !clk_q) begin
      per <= ccnt + 1;
      ccnt <= 0;
      rises <= rises + 1;
    end
    if (sample_strobe) begin
      n_strobe <= n_strobe + 1;
      gap <= rises;
      rises <= 0;
    end
  end
  task automatic end_of_test;
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic hang;
    chk(32'h0, 32'h1);
    end_of_test();
  endtask : hang
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    int k = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'h0};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 20);
    if (k >= 20) hang();
    rdat = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : bus
  task automatic wait_flag;
    int k = 0;
    do begin
      bus(1'h0, CS, 8'h00);
      k++;
    end while (rdat[4] !== 1'h1 && k < 3000);
    if (k >= 3000) hang();
  endtask : wait_flag
  // low byte first: it freezes the pair until the high byte is read
  task automatic res(input logic [9:0] v, input logic lj);
    bus(1'h0, acc_pkg::IDX_RESULT_LOW, 8'h00);
    lo = rdat;
    bus(1'h0, acc_pkg::IDX_RESULT_HIGH, 8'h00);
    chk({rdat, lo}, lj ? {v, 6'h00} : {6'h00, v});
  endtask : res
  initial begin
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {global_irq_enable, irq_vector_ack, cpu_sleep_halt} = 3'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, nxt} = {8'h00, 4'hF, 32'h0, 10'h000};
    void'($urandom(32'hD5B8));
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'h0;
    bus(1'h0, CS, 8'h00);
    chk(rdat, acc_pkg::CTRL_STATUS_RESET);
    bus(1'h0, 6'h00, 8'h00);
    chk(rdat, 8'h00);
    // only divide 128 keeps the clock under 200 kHz; others trade bits
    for (int k = 0; k < 8; k++) begin
      ir = 8'($urandom);
      nxt <= 10'($urandom);
      global_irq_enable <= k[0];
      bus(1'h1, IR, ir);
      bus(1'h1, CS, 8'hC8 | 8'(k));
      base = n_strobe;
      bus(1'h0, CS, 8'h00);
      chk(rdat[6], 1'h1);
      // let the conversion get under way before changing the selection
      n = 0;
      while (n_strobe == base && n < 4000) begin
        @(posedge core_clk);
        n++;
      end
      if (n >= 4000) hang();
      bus(1'h1, CS, 8'h88 | 8'(k));
      bus(1'h1, IR, ~ir);
      chk({active_reference, active_channel}, {ir[7:6], ir[4:0]});
      wait_flag();
      chk(rdat[6], 1'h0);
      chk(n_strobe - base, 2);
      chk(gap, 13);
      chk(per, k == 0 ? 2 : 1 << k);
      chk({active_reference, active_channel}, {~ir[7:6], ~ir[4:0]});
      chk({internal_ref_on, channel_reserved},
          {~ir[7:6] == acc_pkg::REF_INTERNAL,
           ~ir[4:0] > 5'h07 && ~ir[4:0] < 5'h1E});
      chk(done_irq_request, k[0]);
      res(nxt, ~ir[5]);
      if (k[0]) begin
        irq_vector_ack <= 1'h1;
        @(posedge core_clk);
        irq_vector_ack <= 1'h0;
      end else bus(1'h1, CS, 8'h98 | 8'(k));
      bus(1'h0, CS, 8'h00);
      chk(rdat[4], 1'h0);
      bus(1'h1, CS, 8'h00);
    end
    bus(1'h1, IR, 8'h00);
    nxt <= 10'h2A5;
    bus(1'h1, CS, 8'hE1);
    wait_flag();
    bus(1'h1, CS, 8'hB1);
    wait_flag();
    chk(rdat[6], 1'h1);
    chk(gap, 13);
    bus(1'h0, acc_pkg::IDX_RESULT_LOW, 8'h00);
    lo = rdat;
    nxt <= 10'h15A;
    repeat (2) begin
      bus(1'h1, CS, 8'hB1);
      wait_flag();
    end
    bus(1'h0, acc_pkg::IDX_RESULT_HIGH, 8'h00);
    chk({rdat, lo}, 16'h02A5);
    bus(1'h1, CS, 8'hB1);
    wait_flag();
    res(10'h15A, 1'h0);
    bus(1'h1, CS, 8'h91);
    wait_flag();
    base = n_strobe;
    repeat (100) @(posedge core_clk);
    chk(n_strobe - base, 0);
    bus(1'h1, CS, 8'hD1);
    bus(1'h1, CS, 8'h00);
    repeat (200) @(posedge core_clk);
    bus(1'h0, CS, 8'h00);
    chk({rdat, converter_clk, converter_power}, 10'h000);
    global_irq_enable <= 1'h1;
    bus(1'h1, CS, 8'h89);
    base = n_strobe;
    cpu_sleep_halt <= 1'h1;
    n = 0;
    while (cpu_wake !== 1'h1) begin
      @(posedge core_clk);
      n++;
      if (n > 400) hang();
    end
    chk(n_strobe - base, 2);
    end_of_test();
  end
endmodule : test_adc_conversion_control
